// [core/att_map.svh]
// Address translation hierarchy: field positions, widths and page size codes.
// Assumes 32-bit virtual and physical addresses with 4 KB base frames.
`ifndef ATT_MAP_SVH
`define ATT_MAP_SVH
`define ATT_VA_W      32
`define ATT_PG_SHIFT  12
`define ATT_FRM_W     20
`define ATT_PAIR_W    19
`define ATT_ATTR_W    4
`define ATT_SZ_W      4
`define ATT_SZ_4K     4'h0
`define ATT_SZ_16K    4'h1
`define ATT_SZ_MAX    4'h8
`endif

// [core/att_pkg.sv]
// Types shared by the translation hierarchy.
// Assumes att_map.svh supplies the widths.
`include "att_map.svh"
package att_pkg;
  typedef enum logic {ATT_IDLE, ATT_WALK} att_side_e;
  typedef logic [`ATT_FRM_W-1:0]  att_frm_t;
  typedef logic [`ATT_ATTR_W-1:0] att_attr_t;
  typedef struct packed {
    att_frm_t  vpn;
    logic      big;
    att_frm_t  pfn;
    att_attr_t attr;
  } att_uent_s;
endpackage : att_pkg

// [core/att_tlb_top.sv]
// Translation hierarchy: fetch and data micro TLBs over a variable page TLB; the fixed page TLB backs fetches only.
// Assumes fetch, load/store and the CP0 refill port all run on SYS_CLK.
`timescale 1ns/1ps
module att_tlb_top
  import att_pkg::*;
#(
  parameter int I_ENTRIES = 16,
  parameter int D_ENTRIES = 32,
  parameter int V_ENTRIES = 64,
  parameter int F_SETS    = 128,
  parameter int F_WAYS    = 4
) (
  // Clock and reset
  input  wire logic                    SYS_CLK,
  input  wire logic                    RSTN,
  // Fetch stream
  input  wire logic                    I_REQ,
  input  wire logic [`ATT_VA_W-1:0]    I_VA,
  output logic                         I_READY,
  output logic                         I_DONE,
  output logic [`ATT_VA_W-1:0]         I_PA,
  output logic [`ATT_ATTR_W-1:0]       I_ATTR,
  output logic                         I_EXC,
  // Data stream
  input  wire logic                    D_REQ,
  input  wire logic [`ATT_VA_W-1:0]    D_VA,
  output logic                         D_READY,
  output logic                         D_DONE,
  output logic [`ATT_VA_W-1:0]         D_PA,
  output logic [`ATT_ATTR_W-1:0]       D_ATTR,
  output logic                         D_EXC,
  // Software refill port
  input  wire logic                    WR_VAR,
  input  wire logic                    WR_FIX,
  input  wire logic                    WR_VALID,
  input  wire logic [$clog2(V_ENTRIES)-1:0] WR_IDX,
  input  wire logic [$clog2(F_WAYS)-1:0]    WR_WAY,
  input  wire logic [`ATT_PAIR_W-1:0]  WR_PAIR,
  input  wire logic [`ATT_SZ_W-1:0]    WR_SIZE,
  input  wire logic [`ATT_FRM_W-1:0]   WR_PFN0,
  input  wire logic [`ATT_FRM_W-1:0]   WR_PFN1,
  input  wire logic [`ATT_ATTR_W-1:0]  WR_ATTR0,
  input  wire logic [`ATT_ATTR_W-1:0]  WR_ATTR1,
  // Configuration
  input  wire logic                    CFG_FIX_16K
);
  localparam int IW = $clog2(I_ENTRIES);
  localparam int DW = $clog2(D_ENTRIES);
  localparam int FS = $clog2(F_SETS);
  if (I_ENTRIES < 2 || D_ENTRIES < 2 || V_ENTRIES < 2 || (1 << IW) != I_ENTRIES
      || (1 << DW) != D_ENTRIES || (1 << FS) != F_SETS || FS > `ATT_PAIR_W - 2
      || (1 << $clog2(V_ENTRIES)) != V_ENTRIES || (1 << $clog2(F_WAYS)) != F_WAYS
      || F_WAYS < 2) begin : g_bad_cfg
    $error("att_tlb_top: unsupported entry counts");
  end
  typedef struct packed {
    att_side_e                     i_st;
    att_side_e                     d_st;
    logic [`ATT_VA_W-1:0]          i_va;
    logic [`ATT_VA_W-1:0]          d_va;
    logic [IW-1:0]                 i_rr;
    logic [DW-1:0]                 d_rr;
    logic [I_ENTRIES-1:0]          i_val;
    logic [D_ENTRIES-1:0]          d_val;
    logic [V_ENTRIES-1:0]          v_val;
    logic [F_WAYS*F_SETS-1:0]      f_val;
    logic                          i_done;
    logic                          d_done;
    logic                          i_exc;
    logic                          d_exc;
    logic [`ATT_VA_W-1:0]          i_pa;
    logic [`ATT_VA_W-1:0]          d_pa;
    att_attr_t                     i_attr;
    att_attr_t                     d_attr;
  } att_ctl_s;

  att_ctl_s c_q, c_d;
  // Translation storage; only valid bits need reset
  att_uent_s               i_ent [I_ENTRIES];
  att_uent_s               d_ent [D_ENTRIES];
  logic [`ATT_PAIR_W-1:0]  v_tag [V_ENTRIES];
  logic [`ATT_SZ_W-1:0]    v_sz  [V_ENTRIES];
  att_frm_t                v_pfn [V_ENTRIES][2];
  att_attr_t               v_attr[V_ENTRIES][2];
  logic [`ATT_PAIR_W-1:0]  f_tag [F_WAYS][F_SETS];
  att_frm_t                f_pfn [F_WAYS][F_SETS][2];
  att_attr_t               f_attr[F_WAYS][F_SETS][2];

  function automatic att_frm_t att_lowmask(input logic [`ATT_SZ_W-1:0] sz);
    att_lowmask = (`ATT_FRM_W'(1) << {sz, 1'b0}) - `ATT_FRM_W'(1);
  endfunction : att_lowmask

  function automatic logic att_umatch(input att_uent_s e, input logic [`ATT_VA_W-1:0] va);
    if (e.big) begin
      att_umatch = (e.vpn[`ATT_FRM_W-1:2] == va[`ATT_VA_W-1:`ATT_PG_SHIFT+2]);
    end else begin
      att_umatch = (e.vpn == va[`ATT_VA_W-1:`ATT_PG_SHIFT]);
    end
  endfunction : att_umatch

  function automatic logic [`ATT_VA_W-1:0] att_pa(input att_uent_s e,
                                                  input logic [`ATT_VA_W-1:0] va);
    att_pa = {e.pfn, va[`ATT_PG_SHIFT-1:0]};
    if (e.big) begin
      att_pa[`ATT_PG_SHIFT+1:`ATT_PG_SHIFT] = va[`ATT_PG_SHIFT+1:`ATT_PG_SHIFT];
    end
  endfunction : att_pa

  // Micro lookups, one comparator per entry
  logic [I_ENTRIES-1:0] i_hv;
  logic [D_ENTRIES-1:0] d_hv;
  for (genvar e = 0; e < I_ENTRIES; e++) begin : g_ihit
    assign i_hv[e] = c_q.i_val[e] && att_umatch(i_ent[e], I_VA);
  end
  for (genvar e = 0; e < D_ENTRIES; e++) begin : g_dhit
    assign d_hv[e] = c_q.d_val[e] && att_umatch(d_ent[e], D_VA);
  end

  // Backing walker: fetch side wins when both wait
  logic                    gnt_i;
  logic                    gnt_d;
  logic [`ATT_VA_W-1:0]    bva;
  assign gnt_i = (c_q.i_st == ATT_WALK);
  assign gnt_d = (c_q.d_st == ATT_WALK) && !gnt_i;
  assign bva   = gnt_i ? c_q.i_va : c_q.d_va;
  logic [`ATT_PAIR_W-1:0]  bpair;
  logic [V_ENTRIES-1:0]    v_hv;
  assign bpair = bva[`ATT_VA_W-1:`ATT_PG_SHIFT+1];
  for (genvar e = 0; e < V_ENTRIES; e++) begin : g_vhit
    logic [`ATT_PAIR_W-1:0] m;
    assign m       = `ATT_PAIR_W'(att_lowmask(v_sz[e]));
    assign v_hv[e] = c_q.v_val[e] && ((bpair & ~m) == (v_tag[e] & ~m));
  end
  // Fixed page TLB index and tag follow the configured page size
  logic [`ATT_PAIR_W-1:0]  fpair;
  logic [`ATT_PAIR_W-1:0]  wpair;
  logic [FS-1:0]           fset;
  logic [FS-1:0]           wset;
  logic                    fodd;
  assign fpair = CFG_FIX_16K ? {2'h0, bva[`ATT_VA_W-1:`ATT_PG_SHIFT+3]} : bpair;
  assign wpair = CFG_FIX_16K ? {2'h0, WR_PAIR[`ATT_PAIR_W-1:2]} : WR_PAIR;
  assign fset  = fpair[FS-1:0];
  assign wset  = wpair[FS-1:0];
  assign fodd  = CFG_FIX_16K ? bva[`ATT_PG_SHIFT+2] : bva[`ATT_PG_SHIFT];
  logic        b_hit;
  att_frm_t    b_frm;
  logic        b_big;
  att_attr_t   b_attr;

  always_comb begin
    logic      odd;
    att_frm_t  lm;
    b_hit  = 1'b0;
    b_frm  = '0;
    b_big  = 1'b0;
    b_attr = '0;
    odd    = 1'b0;
    lm     = '0;
    // Fixed page TLB only for fetches; variable page hit takes precedence
    if (gnt_i) begin
      for (int w = F_WAYS - 1; w >= 0; w--) begin
        if (c_q.f_val[w*F_SETS + int'(fset)] && f_tag[w][fset] == fpair) begin
          b_hit  = 1'b1;
          b_big  = CFG_FIX_16K;
          b_frm  = f_pfn[w][fset][fodd];
          b_attr = f_attr[w][fset][fodd];
          if (CFG_FIX_16K) begin
            b_frm[1:0] = bva[`ATT_PG_SHIFT+1:`ATT_PG_SHIFT];
          end
        end
      end
    end
    for (int e = V_ENTRIES - 1; e >= 0; e--) begin
      if (v_hv[e]) begin
        lm     = att_lowmask(v_sz[e]);
        odd    = bva[`ATT_PG_SHIFT + 2*int'(v_sz[e])];
        b_hit  = 1'b1;
        b_big  = (v_sz[e] != `ATT_SZ_4K);
        // Split: keep only the 4 KB or 16 KB piece holding the address
        b_frm  = v_pfn[e][odd] | (bva[`ATT_VA_W-1:`ATT_PG_SHIFT] & lm);
        b_attr = v_attr[e][odd];
      end
    end
  end

  att_uent_s ins_ent;
  always_comb begin
    ins_ent.vpn  = bva[`ATT_VA_W-1:`ATT_PG_SHIFT];
    ins_ent.big  = b_big;
    ins_ent.pfn  = b_frm;
    ins_ent.attr = b_attr;
    if (b_big) begin
      ins_ent.vpn[1:0] = 2'h0;
      ins_ent.pfn[1:0] = 2'h0;
    end
  end

  logic i_ins;
  logic d_ins;
  logic wr_any;
  assign i_ins  = gnt_i && b_hit;
  assign d_ins  = gnt_d && b_hit;
  assign wr_any = WR_VAR || WR_FIX;

  always_comb begin
    int hi;
    int hd;
    c_d        = c_q;
    c_d.i_done = 1'b0;
    c_d.d_done = 1'b0;
    hi = -1;
    hd = -1;
    for (int e = I_ENTRIES - 1; e >= 0; e--) begin
      if (i_hv[e]) hi = e;
    end
    for (int e = D_ENTRIES - 1; e >= 0; e--) begin
      if (d_hv[e]) hd = e;
    end
    // Fetch side
    if (c_q.i_st == ATT_IDLE && I_REQ) begin
      if (hi >= 0) begin
        c_d.i_done = 1'b1;
        c_d.i_exc  = 1'b0;
        c_d.i_pa   = att_pa(i_ent[hi], I_VA);
        c_d.i_attr = i_ent[hi].attr;
      end else begin
        c_d.i_st = ATT_WALK;
        c_d.i_va = I_VA;
      end
    end else if (gnt_i) begin
      c_d.i_st   = ATT_IDLE;
      c_d.i_done = 1'b1;
      c_d.i_exc  = !b_hit;
      c_d.i_pa   = att_pa(ins_ent, bva);
      c_d.i_attr = b_attr;
      if (b_hit) begin
        c_d.i_val[c_q.i_rr] = 1'b1;
        c_d.i_rr = c_q.i_rr + IW'(1);
      end
    end
    // Data side; waits while the fetch side holds the walker
    if (c_q.d_st == ATT_IDLE && D_REQ) begin
      if (hd >= 0) begin
        c_d.d_done = 1'b1;
        c_d.d_exc  = 1'b0;
        c_d.d_pa   = att_pa(d_ent[hd], D_VA);
        c_d.d_attr = d_ent[hd].attr;
      end else begin
        c_d.d_st = ATT_WALK;
        c_d.d_va = D_VA;
      end
    end else if (gnt_d) begin
      c_d.d_st   = ATT_IDLE;
      c_d.d_done = 1'b1;
      c_d.d_exc  = !b_hit;
      c_d.d_pa   = att_pa(ins_ent, bva);
      c_d.d_attr = b_attr;
      if (b_hit) begin
        c_d.d_val[c_q.d_rr] = 1'b1;
        c_d.d_rr = c_q.d_rr + DW'(1);
      end
    end
    // Refill port; a backing change flushes both micro TLBs to avoid stale copies
    if (WR_VAR) begin
      c_d.v_val[WR_IDX] = WR_VALID;
    end
    if (WR_FIX) begin
      c_d.f_val[int'(WR_WAY)*F_SETS + int'(wset)] = WR_VALID;
    end
    if (wr_any) begin
      c_d.i_val = '0;
      c_d.d_val = '0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      c_q      <= '0;
      c_q.i_st <= ATT_IDLE;
      c_q.d_st <= ATT_IDLE;
    end else begin
      c_q <= c_d;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (i_ins) begin
      i_ent[c_q.i_rr] <= ins_ent;
    end
    if (d_ins) begin
      d_ent[c_q.d_rr] <= ins_ent;
    end
    if (WR_VAR) begin
      v_tag[WR_IDX]     <= WR_PAIR;
      v_sz[WR_IDX]      <= (WR_SIZE > `ATT_SZ_MAX) ? `ATT_SZ_MAX : WR_SIZE;
      v_pfn[WR_IDX][0]  <= WR_PFN0;
      v_pfn[WR_IDX][1]  <= WR_PFN1;
      v_attr[WR_IDX][0] <= WR_ATTR0;
      v_attr[WR_IDX][1] <= WR_ATTR1;
    end
    if (WR_FIX) begin
      f_tag[WR_WAY][wset]     <= wpair;
      f_pfn[WR_WAY][wset][0]  <= WR_PFN0;
      f_pfn[WR_WAY][wset][1]  <= WR_PFN1;
      f_attr[WR_WAY][wset][0] <= WR_ATTR0;
      f_attr[WR_WAY][wset][1] <= WR_ATTR1;
    end
  end
  assign I_READY = (c_q.i_st == ATT_IDLE);
  assign D_READY = (c_q.d_st == ATT_IDLE);
  assign I_DONE  = c_q.i_done;
  assign I_PA    = c_q.i_pa;
  assign I_ATTR  = c_q.i_attr;
  assign I_EXC   = c_q.i_exc;
  assign D_DONE  = c_q.d_done;
  assign D_PA    = c_q.d_pa;
  assign D_ATTR  = c_q.d_attr;
  assign D_EXC   = c_q.d_exc;
endmodule : att_tlb_top

// [verification/att_tlb_props.sv]
// Checker for the fetch and data translation ports.
// Assumes it is bound to att_tlb_top and sees only its ports.
`timescale 1ns/1ps
`include "att_map.svh"
module att_tlb_props (
  // Clock and reset
  input wire logic                 SYS_CLK,
  input wire logic                 RSTN,
  // Fetch stream
  input wire logic                 I_REQ,
  input wire logic                 I_READY,
  input wire logic                 I_DONE,
  input wire logic [`ATT_VA_W-1:0] I_PA,
  input wire logic                 I_EXC,
  // Data stream
  input wire logic                 D_REQ,
  input wire logic                 D_READY,
  input wire logic                 D_DONE,
  input wire logic [`ATT_VA_W-1:0] D_PA,
  input wire logic                 D_EXC
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  chk_fetch_answer: assert property (I_REQ && I_READY |=> I_DONE || !I_READY)
    else $error("fetch request neither answered nor stalled");
  chk_fetch_walk: assert property (!I_READY |=> I_DONE && I_READY)
    else $error("fetch walk longer than one cycle");
  chk_data_answer: assert property (D_REQ && D_READY |-> ##[1:3] D_DONE)
    else $error("data request not answered in time");
  chk_data_stall: assert property (!D_READY |-> !D_DONE)
    else $error("data answer while port stalled");
  chk_fetch_hit_ok: assert property (I_REQ && I_READY ##1 I_DONE |-> !I_EXC)
    else $error("fetch micro hit flagged an exception");
  chk_data_hit_ok: assert property (D_REQ && D_READY ##1 D_DONE |-> !D_EXC)
    else $error("data micro hit flagged an exception");
  chk_fetch_cause: assert property (I_DONE && $past(I_READY) |-> $past(I_REQ))
    else $error("fetch answer without request");
  chk_fetch_hold: assert property (!I_DONE |-> $stable(I_PA) && $stable(I_EXC))
    else $error("fetch result changed between answers");
  chk_data_hold: assert property (!D_DONE |-> $stable(D_PA) && $stable(D_EXC))
    else $error("data result changed between answers");
  // Fetch owns the walker, so a data miss taken with a fetch miss waits a cycle
  chk_fetch_prio: assert property (I_REQ && I_READY && D_REQ && D_READY ##1
    !I_READY && !D_READY |=> !D_DONE) else $error("data walk did not yield to fetch");

  cov_fetch_miss: cover property (I_REQ && I_READY ##1 !I_READY ##1 I_DONE);
  cov_data_wait: cover property (!D_READY [*2] ##1 D_DONE);
  cov_fetch_exc: cover property (I_DONE && I_EXC);
endmodule : att_tlb_props

bind att_tlb_top att_tlb_props u_props (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
  .I_REQ(I_REQ), .I_READY(I_READY), .I_DONE(I_DONE), .I_PA(I_PA), .I_EXC(I_EXC),
  .D_REQ(D_REQ), .D_READY(D_READY), .D_DONE(D_DONE), .D_PA(D_PA), .D_EXC(D_EXC));

// [verification/att_pipe_model.sv]
// Requester model of a fetch or load/store pipeline stage.
// Assumes the bench pushes addresses; it stalls at random between requests.
`timescale 1ns/1ps
`include "att_map.svh"
module att_pipe_model (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rstn,
  // Bench command
  input wire logic                 push,
  input wire logic [`ATT_VA_W-1:0] push_va,
  // Request port
  output logic                     req,
  output logic [`ATT_VA_W-1:0]     va,
  input wire logic                 ready
);
  logic [`ATT_VA_W-1:0] pend[$];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req <= 1'b0;
      va  <= '0;
    end else begin
      if (push)
        pend.push_back(push_va);
      // Held until taken; back to back when more is pending and the random draw is not 0
      if (req && ready && pend.size() == 0) begin
        req <= 1'b0;
        va  <= ~va;
      end else if ((!req || ready) && pend.size() != 0 && $urandom_range(3) != 0) begin
        req <= 1'b1;
        va  <= pend.pop_front();
      end else if (req && ready) begin
        req <= 1'b0;
        va  <= ~va;
      end
    end
  end
endmodule : att_pipe_model

// [verification/test_att_tlb_top.sv]
// Self-checking bench for the translation hierarchy.
// Assumes two requester models feed the fetch and data ports.
`timescale 1ns/1ps
`include "att_map.svh"
module test_att_tlb_top;
  import att_pkg::*;
  typedef struct packed {logic miss; logic exc; logic [31:0] pa; att_attr_t attr;} att_exp_s;
  logic        clk = 1'b0, rstn = 1'b0, ip = 1'b0, dp = 1'b0, wv = 1'b0, wf = 1'b0;
  logic        wval = 1'b0, cfg = 1'b0, i_rp = 1'b1, d_rp = 1'b1;
  logic        i_req, i_rdy, i_done, i_exc, d_req, d_rdy, d_done, d_exc;
  logic [31:0] pva = '0, i_va, i_pa, d_va, d_pa;
  logic [5:0]  widx = '0;
  logic [18:0] wvpn = '0;
  logic [3:0]  wsz = '0;
  logic [19:0] pf[2] = '{20'h0, 20'h0};
  att_attr_t   at[2] = '{4'h0, 4'h0};
  att_attr_t   i_attr, d_attr;
  att_exp_s    exp_i[$], exp_d[$];
  logic [11:0] off;
  int          n_fail = 0, cmp_count = 0, n, m, k;

  always #25 clk = ~clk;

  att_tlb_top uut (.SYS_CLK(clk), .RSTN(rstn),
    .I_REQ(i_req), .I_VA(i_va), .I_READY(i_rdy), .I_DONE(i_done), .I_PA(i_pa),
    .I_ATTR(i_attr), .I_EXC(i_exc), .D_REQ(d_req), .D_VA(d_va), .D_READY(d_rdy),
    .D_DONE(d_done), .D_PA(d_pa), .D_ATTR(d_attr), .D_EXC(d_exc),
    .WR_VAR(wv), .WR_FIX(wf), .WR_VALID(wval), .WR_IDX(widx), .WR_WAY(widx[1:0]),
    .WR_PAIR(wvpn), .WR_SIZE(wsz), .WR_PFN0(pf[0]), .WR_PFN1(pf[1]),
    .WR_ATTR0(at[0]), .WR_ATTR1(at[1]), .CFG_FIX_16K(cfg));
  att_pipe_model u_fetch (.clk(clk), .rstn(rstn), .push(ip), .push_va(pva),
    .req(i_req), .va(i_va), .ready(i_rdy));
  att_pipe_model u_data (.clk(clk), .rstn(rstn), .push(dp), .push_va(pva),
    .req(d_req), .va(d_va), .ready(d_rdy));

  task cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t exp %h got %h", $time, exp, got);
    end
  endtask : cmp_bit

  // Address and attributes are meaningless on an exception
  task cmp_res(input att_exp_s e, input logic miss, input logic exc,
               input logic [31:0] pa, input att_attr_t a);
    cmp_count++;
    if (miss !== e.miss || exc !== e.exc || (!e.exc && (pa !== e.pa || a !== e.attr))) begin
      n_fail++;
      $display("Error %0t exp %h got %h", $time, e, {miss, exc, pa, a});
    end
  endtask : cmp_res

  // Side 0 fetch, 1 data, 2 both at once
  task issue(input int s, input logic [31:0] va, input logic mi, input logic x,
             input logic [31:0] pa, input att_attr_t a);
    @(posedge clk);
    ip <= (s != 1);
    dp <= (s != 0);
    pva <= va;
    if (s != 1) exp_i.push_back({mi, x, pa, a});
    if (s != 0) exp_d.push_back({mi, x, pa, a});
  endtask : issue

  task settle;
    @(posedge clk);
    ip <= 1'b0;
    dp <= 1'b0;
    for (n = 0; n < 3000 && exp_i.size() + exp_d.size() != 0; n++) @(posedge clk);
    if (n == 3000) n_fail++;
    repeat (2) @(posedge clk);
  endtask : settle

  task wr(input logic f, input logic v, input logic [5:0] idx, input logic [18:0] vpn,
          input logic [3:0] sz);
    @(posedge clk);
    ip <= 1'b0;
    dp <= 1'b0;
    wv <= !f;
    wf <= f;
    wval <= v;
    widx <= idx;
    wvpn <= vpn;
    wsz <= sz;
    @(posedge clk);
    wv <= 1'b0;
    wf <= 1'b0;
  endtask : wr

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // Miss is seen as a stalled port in the cycle before the answer
  always @(negedge clk) begin
    if (rstn && i_done === 1'b1) begin
      if (exp_i.size() == 0) cmp_bit(1'b1, 1'b0);
      else cmp_res(exp_i.pop_front(), !i_rp, i_exc, i_pa, i_attr);
    end
    if (rstn && d_done === 1'b1) begin
      if (exp_d.size() == 0) cmp_bit(1'b1, 1'b0);
      else cmp_res(exp_d.pop_front(), !d_rp, d_exc, d_pa, d_attr);
    end
    i_rp = i_rdy;
    d_rp = d_rdy;
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict;
  end

  initial begin
    n = $urandom(98460);
    repeat (2) @(posedge clk);
    cmp_bit(i_rdy & d_rdy & !i_done & !d_done, 1'b1);
    rstn <= 1'b1;
    pf[0] <= 20'($urandom);
    pf[1] <= 20'($urandom);
    at[0] <= 4'($urandom);
    at[1] <= 4'($urandom);
    off = 12'($urandom);
    wr(1'b0, 1'b1, 6'h05, 19'h00091, 4'h0);
    for (int s = 0; s < 2; s++)
      for (int p = 0; p < 2; p++)
        for (int h = 0; h < 2; h++)
          issue(s, {19'h00091, p[0], off}, !h, 0, {pf[p], off}, at[p]);
    settle;
    wr(1'b1, 1'b1, 6'h02, 19'h055E0, 4'h0);
    issue(0, {19'h055E0, 1'b1, off}, 1, 0, {pf[1], off}, at[1]);
    issue(0, {19'h055E0, 1'b1, off}, 0, 0, {pf[1], off}, at[1]);
    issue(1, {19'h055E0, 1'b1, off}, 1, 1, '0, '0);
    issue(0, {19'h00091, 1'b0, off}, 1, 0, {pf[0], off}, at[0]);
    settle;
    wr(1'b0, 1'b0, 6'h05, 19'h00091, 4'h0);
    issue(0, {19'h00091, 1'b0, off}, 1, 1, '0, '0);
    pf[0] <= 20'($urandom) & 20'hFFFF0;
    wr(1'b0, 1'b1, 6'h09, 19'h02800, 4'h2);
    issue(0, 32'h0500_4ABC, 1, 0, {pf[0][19:4], 16'h4ABC}, at[0]);
    issue(0, 32'h0500_7123, 0, 0, {pf[0][19:4], 16'h7123}, at[0]);
    issue(0, 32'h0500_8ABC, 1, 0, {pf[0][19:4], 16'h8ABC}, at[0]);
    settle;
    pf[0] <= 20'h40000;
    wr(1'b0, 1'b1, 6'h00, 19'h10000, 4'h8);
    for (int s = 0; s < 2; s++) begin
      m = s ? 32 : 16;
      for (int j = 0; j < m + 3; j++) begin
        k = (j <= m) ? j : (j == m + 1) ? 2 : 0;
        issue(s, 32'h2000_0000 + k * 32'h4000 + off, j != m + 1, 0,
              32'h4000_0000 + k * 32'h4000 + off, at[0]);
      end
    end
    settle;
    // Empty the fixed TLB before switching it to 16 KB pages
    wr(1'b1, 1'b0, 6'h02, 19'h055E0, 4'h0);
    cfg <= 1'b1;
    wr(1'b1, 1'b1, 6'h01, 19'h04444, 4'h0);
    issue(0, {17'h01111, 3'h5, off}, 1, 0, {pf[1][19:2], 2'h1, off}, at[1]);
    issue(0, {17'h01111, 3'h6, off}, 0, 0, {pf[1][19:2], 2'h2, off}, at[1]);
    for (int j = 0; j < 4; j++)
      issue(2, 32'hF000_0000 + j * 32'h0010_0000, 1, 1, '0, '0);
    settle;
    print_verdict;
  end
endmodule : test_att_tlb_top
